// [hw/cbp_pkg.sv]
// Constants, state codes and the sense bundle of the buck sequencer.
// Assumes a 25 MHz MCLK and sense codes given in millivolts.
package cbp_pkg;
	localparam int CLK_NS = 40;
	localparam int MIN_OFF_NS = 350;
	localparam int ON_SCALE_NS = 2560;
	localparam int ON_OFFS_NS = 35;
	localparam int FILT_NS = 5000;
	localparam logic [7:0] MIN_OFF_CYC = 8'((MIN_OFF_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] FILT_CYC = 8'((FILT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] ZC_COUNT = 4'h8;
	localparam logic [3:0] UV_COUNT = 4'h8;
	localparam logic [3:0] SS_STEP_CYC = 4'h8;
	localparam logic [5:0] HALF_OC_CYC = 6'h20;
	// Levels in millivolts on the divided feedback, then the under-voltage ratio.
	localparam logic [9:0] REF_MV = 10'h2EE;
	localparam logic [9:0] STEP_MV = 10'h01E;
	localparam logic [9:0] SNAP_STOP_MV = 10'h294;
	localparam logic [9:0] OV8_MV = 10'h32A;
	localparam logic [9:0] OV20_MV = 10'h384;
	localparam logic [9:0] PG_LOW_MV = 10'h294;
	localparam logic [9:0] PG_HIGH_MV = 10'h29C;
	localparam logic [13:0] UV_NUM = 14'h0007;
	localparam logic [13:0] UV_DEN = 14'h000A;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DTH = 6'h02,
		ST_HIGH = 6'h04,
		ST_DTL = 6'h08,
		ST_LOW = 6'h10,
		ST_SKIP = 6'h20
	} cbp_state_t;
	typedef struct packed {
		logic [9:0] fb_mv;
		logic [12:0] out_mv;
		logic [14:0] bat_mv;
		logic zc;
		logic lim;
		logic en;
		logic sup;
	} cbp_sense_t;
endpackage

// [hw/cbp_seq.sv]
// Sequencer of a constant on-time synchronous buck controller.
// Assumes converters give millivolt codes held steady for three clocks.
// Function
// - Keep at least 350 ns high-side off before the next on interval.
// - On interval is 2560*out/battery plus 35 ns.
// - New cycle is needed when feedback is at or below the reference.
// - On feedback trip, low side goes off, then high side turns on.
// - Enable low keeps both gate drives off; enable high runs the controller.
// - Eight zero-cross cycles enter light load; low side stops at zero.
// - Light load lengthens on interval by a quarter.
// - Any cycle without zero cross leaves light load at once.
// - Feedback above 810 mV leaves light load and holds low side on.
// - Back at the trip point, a normal on cycle starts.
// - Limit source is on whenever, and only while, the low side conducts.
// - While current limit trips, the next high-side pulse waits.
// - Power good falls below -12 percent, returns above -11 percent.
// - Power good stays low until soft-start reaches 0.75 V.
// - Power good changes pass a 5 us filter; lows forced when not running skip it.
// - Power good low above +20 percent or when enable is low.
// - Over +20 percent for 5 us latches low side on until re-enable.
// - Thirty percent under for eight clocks latches both drives off.
// - Supply low inhibits switching; its return clears faults, soft-start.
// - Soft-start climbs the reference in 30 mV steps of eight clocks.
// - Zero cross in soft-start snaps reference to feedback below 660 mV.
// - First 32 cycles run with half over-current threshold.
// - Never overlap the gate drives; one dead clock between them.
`timescale 1ns/1ps
module cbp_seq (
	// Clock and reset.
	input wire logic MCLK,
	input wire logic SRST,
	// Control and comparator inputs, asynchronous.
	input wire logic ENABLE,
	input wire logic BIAS_SUPPLY_OK,
	input wire logic ZERO_CROSS,
	input wire logic CURRENT_LIMIT_TRIP,
	// Sense codes in millivolts, asynchronous.
	input wire logic [9:0] FEEDBACK_SENSE_MV,
	input wire logic [12:0] OUTPUT_SENSE_MV,
	input wire logic [14:0] BATTERY_MV,
	// Gate drives and analog controls.
	output logic HIGH_SIDE_GATE_DRIVE,
	output logic LOW_SIDE_GATE_DRIVE,
	output logic LIMIT_SET_SRC_EN,
	output logic LIMIT_HALF,
	// Open-drain power good, low while pulling the pin down.
	output logic POWER_OK_PIN_OE_N
);
	cbp_pkg::cbp_sense_t s1_ff, s2_ff, sen;
	cbp_pkg::cbp_state_t state_ff, nxt_state;
	logic dh_ff, dl_ff, src_ff, half_ff, pg_ff;
	logic ov_ff, uv_ff, lite_ff, zc_seen_ff, pg_ok_ff;
	logic [7:0] on_cnt_ff, off_cnt_ff, ov_cnt_ff, pg_cnt_ff;
	logic [3:0] zc_cnt_ff, uv_cnt_ff, step_ff;
	logic [5:0] cyc_ff;
	logic [9:0] ref_ff;
	logic run, trip, over8, over20, under30, start_ok, new_cyc;
	logic ss_done, snap, pg_raw;

	// Zero-cycle on intervals cannot occur; the offset alone rounds up to one clock.
	function automatic logic [7:0] on_cycles(input logic [12:0] o, input logic [14:0] b,
		input logic ext);
		logic [31:0] ns;
		ns = 32'(cbp_pkg::ON_SCALE_NS);
		if (b > {2'h0, o}) begin
			ns = ({19'h0, o} * 32'(cbp_pkg::ON_SCALE_NS)) / {17'h0, b};
		end
		ns = ns + 32'(cbp_pkg::ON_OFFS_NS);
		if (ext) begin
			ns = ns + (ns >> 2);
		end
		return 8'((ns + 32'(cbp_pkg::CLK_NS) - 32'h1) / 32'(cbp_pkg::CLK_NS));
	endfunction

	// two-stage sync
	// Multi-bit codes rely on the converter holding them, so no word tears.
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			s1_ff <= '0;
			s2_ff <= '0;
		end else begin
			s1_ff <= {FEEDBACK_SENSE_MV, OUTPUT_SENSE_MV, BATTERY_MV,
				ZERO_CROSS, CURRENT_LIMIT_TRIP, ENABLE, BIAS_SUPPLY_OK};
			s2_ff <= s1_ff;
		end
	end

	// Decoded conditions from the synchronised sense bundle.
	assign sen = s2_ff;
	assign run = sen.en && sen.sup && !ov_ff && !uv_ff;
	assign trip = sen.fb_mv <= ref_ff;
	assign over8 = sen.fb_mv > cbp_pkg::OV8_MV;
	assign over20 = sen.fb_mv > cbp_pkg::OV20_MV;
	assign under30 = 14'(sen.fb_mv) * cbp_pkg::UV_DEN < 14'(ref_ff) * cbp_pkg::UV_NUM;
	assign ss_done = ref_ff == cbp_pkg::REF_MV;
	assign start_ok = run && trip && off_cnt_ff == 8'h00 && !sen.lim && !over8;
	assign new_cyc = nxt_state == cbp_pkg::ST_DTH && state_ff != cbp_pkg::ST_DTH;

	// Next state of the switching sequence.
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			cbp_pkg::ST_IDLE: begin
				if (ov_ff) begin
					nxt_state = cbp_pkg::ST_DTL;
				end else if (start_ok) begin
					nxt_state = cbp_pkg::ST_DTH;
				end
			end
			cbp_pkg::ST_DTH: begin
				nxt_state = run ? cbp_pkg::ST_HIGH : cbp_pkg::ST_IDLE;
			end
			cbp_pkg::ST_HIGH: begin
				if (!run) begin
					nxt_state = ov_ff ? cbp_pkg::ST_DTL : cbp_pkg::ST_IDLE;
				end else if (on_cnt_ff <= 8'h01) begin
					nxt_state = cbp_pkg::ST_DTL;
				end
			end
			cbp_pkg::ST_DTL: begin
				nxt_state = (run || ov_ff) ? cbp_pkg::ST_LOW : cbp_pkg::ST_IDLE;
			end
			cbp_pkg::ST_LOW: begin
				if (ov_ff) begin
					nxt_state = cbp_pkg::ST_LOW;
				end else if (!run) begin
					nxt_state = cbp_pkg::ST_IDLE;
				end else if (start_ok) begin
					nxt_state = cbp_pkg::ST_DTH;
				end else if (lite_ff && sen.zc && !over8) begin
					nxt_state = cbp_pkg::ST_SKIP;
				end
			end
			cbp_pkg::ST_SKIP: begin
				if (!run) begin
					nxt_state = cbp_pkg::ST_IDLE;
				end else if (over8) begin
					nxt_state = cbp_pkg::ST_DTL;
				end else if (start_ok) begin
					nxt_state = cbp_pkg::ST_DTH;
				end
			end
			default: nxt_state = cbp_pkg::ST_IDLE;
		endcase
	end

	// State and gate drive flops; drives follow the state one-for-one.
	// lockout keeps drives off
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			state_ff <= cbp_pkg::ST_IDLE;
			dh_ff <= 1'b0;
			dl_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			dh_ff <= nxt_state == cbp_pkg::ST_HIGH;
			dl_ff <= nxt_state == cbp_pkg::ST_LOW;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			src_ff <= 1'b0;
		end else begin
			src_ff <= nxt_state == cbp_pkg::ST_LOW && (state_ff == cbp_pkg::ST_DTL || src_ff);
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			on_cnt_ff <= 8'h00;
		end else if (new_cyc) begin
			on_cnt_ff <= on_cycles(sen.out_mv, sen.bat_mv, lite_ff);
		end else if (state_ff == cbp_pkg::ST_HIGH && on_cnt_ff != 8'h00) begin
			on_cnt_ff <= on_cnt_ff - 8'h01;
		end
	end

	// minimum off one-shot
	// Reloaded while the high side is on, so it times from the falling drive.
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			off_cnt_ff <= 8'h00;
		end else if (dh_ff) begin
			off_cnt_ff <= cbp_pkg::MIN_OFF_CYC;
		end else if (off_cnt_ff != 8'h00) begin
			off_cnt_ff <= off_cnt_ff - 8'h01;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST || !run) begin
			zc_seen_ff <= 1'b0;
			zc_cnt_ff <= 4'h0;
			lite_ff <= 1'b0;
		end else if (new_cyc) begin
			zc_seen_ff <= 1'b0;
			if (zc_seen_ff || state_ff == cbp_pkg::ST_SKIP) begin
				if (zc_cnt_ff != cbp_pkg::ZC_COUNT) begin
					zc_cnt_ff <= zc_cnt_ff + 4'h1;
				end
				lite_ff <= !over8 && (lite_ff || zc_cnt_ff + 4'h1 >= cbp_pkg::ZC_COUNT);
			end else begin
				zc_cnt_ff <= 4'h0;
				lite_ff <= 1'b0;
			end
		end else begin
			zc_seen_ff <= zc_seen_ff || (state_ff == cbp_pkg::ST_LOW && sen.zc);
			if (over8) begin
				lite_ff <= 1'b0;
				zc_cnt_ff <= 4'h0;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST || !run) begin
			cyc_ff <= 6'h00;
			half_ff <= 1'b1;
		end else begin
			if (new_cyc && cyc_ff != cbp_pkg::HALF_OC_CYC) begin
				cyc_ff <= cyc_ff + 6'h01;
			end
			half_ff <= cyc_ff < cbp_pkg::HALF_OC_CYC;
		end
	end

	assign snap = !ss_done && state_ff == cbp_pkg::ST_LOW && sen.zc &&
		sen.fb_mv < cbp_pkg::SNAP_STOP_MV;

	always_ff @(posedge MCLK) begin
		if (SRST || !run) begin
			ref_ff <= 10'h000;
			step_ff <= 4'h0;
		end else if (snap) begin
			ref_ff <= sen.fb_mv;
			step_ff <= 4'h0;
		end else if (!ss_done) begin
			step_ff <= step_ff + 4'h1;
			if (step_ff == cbp_pkg::SS_STEP_CYC - 4'h1) begin
				step_ff <= 4'h0;
				ref_ff <= (ref_ff + cbp_pkg::STEP_MV > cbp_pkg::REF_MV) ?
					cbp_pkg::REF_MV : ref_ff + cbp_pkg::STEP_MV;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST || !sen.en || !sen.sup) begin
			ov_cnt_ff <= 8'h00;
			ov_ff <= 1'b0;
		end else if (ss_done && over20 && !uv_ff) begin
			if (ov_cnt_ff == cbp_pkg::FILT_CYC - 8'h01) begin
				ov_ff <= 1'b1;
			end else begin
				ov_cnt_ff <= ov_cnt_ff + 8'h01;
			end
		end else begin
			ov_cnt_ff <= 8'h00;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST || !sen.en || !sen.sup) begin
			uv_cnt_ff <= 4'h0;
			uv_ff <= 1'b0;
		end else if (run && under30) begin
			if (uv_cnt_ff == cbp_pkg::UV_COUNT - 4'h1) begin
				uv_ff <= 1'b1;
			end else begin
				uv_cnt_ff <= uv_cnt_ff + 4'h1;
			end
		end else begin
			uv_cnt_ff <= 4'h0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			pg_ok_ff <= 1'b0;
		end else if (sen.fb_mv < cbp_pkg::PG_LOW_MV) begin
			pg_ok_ff <= 1'b0;
		end else if (sen.fb_mv >= cbp_pkg::PG_HIGH_MV) begin
			pg_ok_ff <= 1'b1;
		end
	end

	assign pg_raw = ss_done && pg_ok_ff && !over20;

	// forced low
	// Forced lows skip the filter, since a disabled part must not report good.
	always_ff @(posedge MCLK) begin
		if (SRST || !run) begin
			pg_ff <= 1'b0;
			pg_cnt_ff <= 8'h00;
		end else if (pg_raw != pg_ff) begin
			pg_cnt_ff <= pg_cnt_ff + 8'h01;
			if (pg_cnt_ff == cbp_pkg::FILT_CYC - 8'h01) begin
				pg_ff <= pg_raw;
				pg_cnt_ff <= 8'h00;
			end
		end else begin
			pg_cnt_ff <= 8'h00;
		end
	end

	assign HIGH_SIDE_GATE_DRIVE = dh_ff;
	assign LOW_SIDE_GATE_DRIVE = dl_ff;
	assign LIMIT_SET_SRC_EN = src_ff;
	assign LIMIT_HALF = half_ff;
	assign POWER_OK_PIN_OE_N = pg_ff;

	// Helper: clocks the high side has been off, saturating.
	logic [7:0] off_run_ff;
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			off_run_ff <= 8'hFF;
		end else if (dh_ff) begin
			off_run_ff <= 8'h00;
		end else if (off_run_ff != 8'hFF) begin
			off_run_ff <= off_run_ff + 8'h01;
		end
	end

	sequence seq_step;
		!ss_done && !snap && run && step_ff == 4'h7;
	endsequence
	sequence seq_no_zc_cycle;
		new_cyc && !zc_seen_ff && state_ff == cbp_pkg::ST_LOW;
	endsequence

	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);

	a_min_off_gap: assert property ($rose(dh_ff) |-> off_run_ff >= 8'h09)
		else $error("high side restarted inside minimum off time");
	a_no_overlap: assert property ($rose(dh_ff) |-> !dl_ff && !$past(dl_ff))
		else $error("high side rose without a dead clock");
	a_uv_off: assert property ($rose(uv_ff) |=> !dh_ff && !dl_ff)
		else $error("drives not off after under-voltage");
	a_ov_clamp: assert property ($rose(ov_ff) |-> ##[1:3] dl_ff)
		else $error("low side not clamped after over-voltage");
	a_lock_off: assert property (!sen.sup |=> !dh_ff && pg_ff == 1'b0)
		else $error("switching or good while supply low");
	a_pg_start: assert property (!ss_done |=> !pg_ff)
		else $error("power good released during soft-start");
	a_limit_hold: assert property (sen.lim && state_ff != cbp_pkg::ST_DTH |=>
		state_ff != cbp_pkg::ST_DTH)
		else $error("high side started under current limit");
	a_ss_step: assert property (seq_step |=> ref_ff == $past(ref_ff) + 10'h01E
		|| ref_ff == cbp_pkg::REF_MV)
		else $error("reference step wrong");
	a_ref_snap: assert property (snap |=> ref_ff == $past(sen.fb_mv))
		else $error("reference did not follow feedback on zero cross");
	a_lite_exit: assert property (seq_no_zc_cycle |=> !lite_ff)
		else $error("light load kept after cycle without zero cross");
endmodule

// [dv/cbp_fet_model.sv]
// Behavioural model of the external switch pair and inductor current.
// Assumes gate drives come from the sequencer and that MCLK is the only clock.
`timescale 1ns/1ps
module cbp_fet_model (
	// Clock.
	input wire logic clk,
	// Gate drives from the sequencer.
	input wire logic hs,
	input wire logic ls,
	// Load setting from the bench.
	input wire logic light,
	// Zero-current comparator level.
	output logic zc
);
	logic [3:0] ls_cnt_ff;

	// Count how long the low side has been conducting since it turned on.
	always_ff @(posedge clk) begin
		if (!ls) begin
			ls_cnt_ff <= 4'h0;
		end else if (ls_cnt_ff != 4'hF) begin
			ls_cnt_ff <= ls_cnt_ff + 4'h1;
		end
	end

	// At light load the current reaches zero three clocks into the low-side interval.
	// It stays at zero once the low side has let go, and rises whenever the high side conducts.
	always_ff @(posedge clk) begin
		zc <= light && !hs && (!ls || ls_cnt_ff >= 4'h2);
	end
endmodule

// [dv/tb.sv]
// Self-checking bench of the buck sequencer with a model of the switch pair.
// Assumes sense codes in millivolts and a 25 MHz MCLK.
`timescale 1ns/1ps
module tb;
	typedef struct { int out_mv; int bat_mv; int exp_w; } cbp_row_t;
	logic mclk, srst, zc, light, chk_src;
	logic hs, ls, src_en, half, pok_oe_n;
	cbp_pkg::cbp_sense_t s;
	int miscompares, num_checks, cycles, rises, w, last_w, n;
	int o = 100;
	// Expected width is ceil((2560*out/bat + 35) / 40) clocks; bat <= out gives 2595 ns.
	cbp_row_t rows [4] = '{'{1500, 15000, 8}, '{1100, 20000, 5}, '{5000, 5000, 65},
		'{750, 25000, 3}};

	cbp_seq DUT (.MCLK(mclk), .SRST(srst), .ENABLE(s.en), .BIAS_SUPPLY_OK(s.sup),
		.ZERO_CROSS(zc), .CURRENT_LIMIT_TRIP(s.lim), .FEEDBACK_SENSE_MV(s.fb_mv),
		.OUTPUT_SENSE_MV(s.out_mv), .BATTERY_MV(s.bat_mv), .HIGH_SIDE_GATE_DRIVE(hs),
		.LOW_SIDE_GATE_DRIVE(ls), .LIMIT_SET_SRC_EN(src_en), .LIMIT_HALF(half),
		.POWER_OK_PIN_OE_N(pok_oe_n));
	cbp_fet_model FETS (.clk(mclk), .hs(hs), .ls(ls), .light(light), .zc(zc));

	// Free-running 40 ns clock.
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("Checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Inputs change one nanosecond after the edge so no race with the design.
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	// Watch the drives every clock: overlap, off time, pulse width and pulse count.
	always @(posedge mclk) begin
		cycles++;
		// A hang past the ceiling counts as a mismatch and ends the run.
		if (cycles >= 20000) begin
			miscompares++;
			results();
		end else if (!srst) begin
			check(hs & ls, 1'b0);
			if (chk_src && ls) check(src_en, 1'b1);
			check(src_en & ~ls, 1'b0);
			if (hs) begin
				if (w == 0) begin
					rises++;
					check(o >= int'(cbp_pkg::MIN_OFF_CYC), 1);
				end
				w++;
				o = 0;
			end else begin
				if (w != 0) last_w = w;
				w = 0;
				o++;
			end
		end
	end

	// Main sequence: reset, table of on intervals, then the awkward cases.
	initial begin
		s = '0;
		s.en = 1'b1;
		s.sup = 1'b1;
		s.fb_mv = 10'h2BC;
		s.out_mv = 13'd1500;
		s.bat_mv = 15'd15000;
		srst = 1'b1;
		light = 1'b0;
		chk_src = 1'b0;
		cyc(3);
		check({hs, ls, src_en, half, pok_oe_n}, 5'b00010);
		srst = 1'b0;
		cyc(97);
		check(rises, 0);
		check(pok_oe_n, 1'b0);
		check(half, 1'b1);
		cyc(200);
		chk_src = 1'b1;
		foreach (rows[i]) begin
			s.out_mv = 13'(rows[i].out_mv);
			s.bat_mv = 15'(rows[i].bat_mv);
			cyc(200);
			check(last_w, rows[i].exp_w);
		end
		chk_src = 1'b0;
		check(half, 1'b0);
		check(pok_oe_n, 1'b1);
		s.out_mv = 13'd1500;
		s.bat_mv = 15'd15000;
		cyc(100);
		// Valley limit holds off the next pulse until it clears.
		s.lim = 1'b1;
		cyc(5);
		n = rises;
		cyc(60);
		check(rises - n, 0);
		s.lim = 1'b0;
		cyc(40);
		check(rises > n, 1);
		// Light load stretches the pulse by a quarter, a full cycle leaves it.
		light = 1'b1;
		cyc(400);
		check(last_w, 10);
		light = 1'b0;
		cyc(100);
		check(last_w, 8);
		// Excess feedback keeps the low side on until back at the trip point.
		s.fb_mv = 10'h352;
		cyc(20);
		n = rises;
		cyc(40);
		check(ls, 1'b1);
		check(rises - n, 0);
		s.fb_mv = 10'h2BC;
		cyc(40);
		check(rises > n, 1);
		// Power good: filtered fall below 660 mV, hysteresis up to 668 mV.
		s.fb_mv = 10'h28A;
		cyc(60);
		check(pok_oe_n, 1'b1);
		cyc(100);
		check(pok_oe_n, 1'b0);
		s.fb_mv = 10'h298;
		cyc(200);
		check(pok_oe_n, 1'b0);
		s.fb_mv = 10'h2BC;
		cyc(200);
		check(pok_oe_n, 1'b1);
		// Over-voltage latches the low side on until enable toggles.
		s.fb_mv = 10'h3B6;
		cyc(150);
		check({hs, ls, pok_oe_n}, 3'b010);
		s.fb_mv = 10'h2BC;
		cyc(40);
		check({ls, pok_oe_n}, 2'b10);
		s.en = 1'b0;
		cyc(10);
		check({hs, ls, pok_oe_n}, 3'b000);
		n = rises;
		s.en = 1'b1;
		cyc(400);
		check(rises > n, 1);
		// Under-voltage shuts both drives until the supply is recycled.
		s.fb_mv = 10'h190;
		cyc(30);
		n = rises;
		cyc(40);
		check({hs, ls}, 2'b00);
		check(rises - n, 0);
		s.sup = 1'b0;
		cyc(10);
		check({hs, ls, pok_oe_n}, 3'b000);
		// Restart at light load with feedback under 660 mV, so zero cross snaps the ramp.
		s.fb_mv = 10'h280;
		light = 1'b1;
		s.sup = 1'b1;
		n = rises;
		cyc(400);
		check(rises > n, 1);
		results();
	end
endmodule
